// [hdl/dfp_pkg.sv]
package dfp_pkg;
  localparam logic [7:0] ADDR_FLASH_PROG_DATA = 8'hB4;
  localparam logic [7:0] ADDR_FLASH_PROG_CONTROL = 8'h02;
  localparam logic [7:0] RST_FLASH_PROG_DATA = 8'h00;
  localparam logic [7:0] RST_ADDR_SELECT = 8'h00;
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;
  localparam logic [1:0] INS_DATA_READ = 2'h0;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h1;
  localparam logic [1:0] INS_DATA_WRITE = 2'h2;
  localparam logic [1:0] INS_ADDR_READ = 2'h3;
  localparam int BYTE_BITS = 8;
  localparam int LEN_BITS = 3;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {
    DFP_CMD_NONE,
    DFP_CMD_READ,
    DFP_CMD_WRITE,
    DFP_CMD_ERASE
  } dfp_cmd_t;
  typedef enum logic [2:0] {
    DFP_IDLE,
    DFP_INS,
    DFP_ADDR,
    DFP_WLEN,
    DFP_WDATA,
    DFP_RLEN,
    DFP_RDATA,
    DFP_TURN
  } dfp_state_t;
endpackage : dfp_pkg

// [hdl/dfp_link.sv]
// Contract
// - 8-bit read/write programming data register at link address 0xB4, reset zero.
// - Data register carries flash commands, addresses, write data and read data.
// - Command codes 0x06 read, 0x07 write, 0x08 page erase, 0x03 device erase.
// - Link traffic happens only while the device is halted.
// - While halted, link takes over the shared clock/reset pin and data pin.
// - Host selects the data register by loading address-select with 0xB4.
// - Programming enabled by writing 0x02 then 0x01 to the control register.
// - Programming stays enabled until system reset.
module dfp_link #(
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic halted,
  input wire logic debug_clock_pin,
  input wire logic debug_data_pin_in,
  output logic debug_data_pin_out,
  output logic debug_data_pin_oe_n,
  output logic pins_borrowed,
  output logic prog_enabled,
  output logic [7:0] flash_prog_data,
  output logic [7:0] cmd_code,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [DW-1:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready
);
  import dfp_pkg::*;

  logic [2:0] ck_sync_ff, nxt_ck_sync;
  logic [1:0] d_sync_ff, nxt_d_sync;
  dfp_state_t st_ff, nxt_st;
  logic [1:0] ins_ff, nxt_ins;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] addr_sel_ff, nxt_addr_sel;
  logic [7:0] data_ff, nxt_data;
  logic [1:0] unlock_ff, nxt_unlock;
  logic out_ff, nxt_out;
  logic oe_n_ff, nxt_oe_n;
  logic borrow_ff, nxt_borrow;
  logic [7:0] buf_mem_ff [BUF_DEPTH];
  logic [7:0] nxt_buf_mem [BUF_DEPTH];
  logic [1:0] buf_cnt_ff, nxt_buf_cnt;
  logic buf_wp_ff, nxt_buf_wp, buf_rp_ff, nxt_buf_rp;
  logic rd_ready_ff, nxt_rd_ready;
  logic [7:0] flash_rd_ff, nxt_flash_rd;
  logic flash_rd_vld_ff, nxt_flash_rd_vld;
  logic rise, fall, din, push, pop, load_rd;

  function automatic logic cmd_is_valid(input logic [7:0] c);
    cmd_is_valid = (c == CMD_BLOCK_READ) || (c == CMD_BLOCK_WRITE) ||
      (c == CMD_PAGE_ERASE) || (c == CMD_DEVICE_ERASE);
  endfunction : cmd_is_valid

  always_comb begin
    nxt_ck_sync = {ck_sync_ff[1:0], debug_clock_pin};
    nxt_d_sync = {d_sync_ff[0], debug_data_pin_in};
  end
  assign rise = ck_sync_ff[1] & ~ck_sync_ff[2];
  assign fall = ~ck_sync_ff[1] & ck_sync_ff[2];
  assign din = d_sync_ff[1];

  // Two-entry buffer between command data register and flash side
  assign push = nxt_borrow && (st_ff == DFP_WDATA) && rise && (cnt_ff == 3'd7)
    && (ins_ff == INS_DATA_WRITE) && (addr_sel_ff == ADDR_FLASH_PROG_DATA)
    && (buf_cnt_ff != 2'd2) && unlock_ff[1];
  assign pop = cmd_valid && cmd_ready;
  // Flash read byte moves into the data register only while the link is idle
  assign load_rd = flash_rd_vld_ff && (st_ff == DFP_IDLE);
  always_comb begin
    nxt_buf_mem = buf_mem_ff;
    nxt_buf_wp = buf_wp_ff;
    nxt_buf_rp = buf_rp_ff;
    nxt_buf_cnt = buf_cnt_ff;
    if (push) begin
      nxt_buf_mem[buf_wp_ff] = {din, sh_ff[7:1]};
      nxt_buf_wp = ~buf_wp_ff;
    end
    if (pop) begin
      nxt_buf_rp = ~buf_rp_ff;
    end
    if (push && !pop) begin
      nxt_buf_cnt = buf_cnt_ff + 2'd1;
    end else if (pop && !push) begin
      nxt_buf_cnt = buf_cnt_ff - 2'd1;
    end
    nxt_flash_rd = flash_rd_ff;
    nxt_flash_rd_vld = flash_rd_vld_ff;
    if (load_rd) begin
      nxt_flash_rd_vld = 1'b0;
    end
    if (rd_valid && rd_ready_ff) begin
      nxt_flash_rd = rd_data[7:0];
      nxt_flash_rd_vld = 1'b1;
    end
    nxt_rd_ready = ~nxt_flash_rd_vld;
  end

  // Link shifter, LSB first: 2-bit instruction, then 8-bit field
  always_comb begin
    nxt_st = st_ff;
    nxt_ins = ins_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_addr_sel = addr_sel_ff;
    nxt_data = data_ff;
    nxt_unlock = unlock_ff;
    nxt_out = out_ff;
    nxt_oe_n = oe_n_ff;
    nxt_borrow = halted;
    if (!nxt_borrow) begin
      nxt_st = DFP_IDLE;
      nxt_oe_n = 1'b1;
    end else if (rise) begin
      case (st_ff)
        DFP_IDLE: begin
          nxt_st = DFP_INS;
          nxt_ins = {1'b0, din};
        end
        DFP_INS: begin
          nxt_ins = {din, ins_ff[0]};
          nxt_cnt = 3'd0;
          if ({din, ins_ff[0]} == INS_DATA_READ || {din, ins_ff[0]} == INS_ADDR_READ) begin
            nxt_st = DFP_RDATA;
            nxt_sh = ({din, ins_ff[0]} == INS_ADDR_READ) ? addr_sel_ff :
              (addr_sel_ff == ADDR_FLASH_PROG_DATA) ? data_ff : 8'h00;
            nxt_oe_n = 1'b0;
          end else begin
            nxt_st = DFP_WDATA;
          end
        end
        DFP_WDATA: begin
          nxt_sh = {din, sh_ff[7:1]};
          nxt_cnt = cnt_ff + 3'd1;
          if (cnt_ff == 3'd7) begin
            nxt_st = DFP_IDLE;
            if (ins_ff == INS_ADDR_WRITE) begin
              nxt_addr_sel = {din, sh_ff[7:1]};
            end else if (addr_sel_ff == ADDR_FLASH_PROG_CONTROL) begin
              if ({din, sh_ff[7:1]} == UNLOCK_FIRST && !unlock_ff[1]) begin
                nxt_unlock = 2'b01;
              end else if ({din, sh_ff[7:1]} == UNLOCK_SECOND && unlock_ff == 2'b01) begin
                nxt_unlock = 2'b10;
              end else if (!unlock_ff[1]) begin
                nxt_unlock = 2'b00;
              end
            end else if (addr_sel_ff == ADDR_FLASH_PROG_DATA) begin
              nxt_data = {din, sh_ff[7:1]};
            end
          end
        end
        DFP_RDATA: begin
          nxt_cnt = cnt_ff + 3'd1;
          if (cnt_ff == 3'd7) begin
            nxt_st = DFP_TURN;
          end
        end
        default: begin
          nxt_st = DFP_IDLE;
        end
      endcase
    end else if (fall && st_ff == DFP_RDATA) begin
      nxt_out = sh_ff[0];
      nxt_sh = {1'b0, sh_ff[7:1]};
    end else if (fall && st_ff == DFP_TURN) begin
      nxt_oe_n = 1'b1;
      nxt_st = DFP_IDLE;
    end
    if (load_rd) begin
      nxt_data = flash_rd_ff;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_sync_ff <= 3'b000;
      d_sync_ff <= 2'b00;
      st_ff <= DFP_IDLE;
      ins_ff <= 2'b00;
      cnt_ff <= 3'd0;
      sh_ff <= 8'h00;
      addr_sel_ff <= RST_ADDR_SELECT;
      data_ff <= RST_FLASH_PROG_DATA;
      unlock_ff <= 2'b00;
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      borrow_ff <= 1'b0;
      buf_mem_ff[0] <= 8'h00;
      buf_mem_ff[1] <= 8'h00;
      buf_cnt_ff <= 2'd0;
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      rd_ready_ff <= 1'b0;
      flash_rd_ff <= 8'h00;
      flash_rd_vld_ff <= 1'b0;
      cmd_code <= 8'h00;
      cmd_valid <= 1'b0;
    end else begin
      ck_sync_ff <= nxt_ck_sync;
      d_sync_ff <= nxt_d_sync;
      st_ff <= nxt_st;
      ins_ff <= nxt_ins;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      addr_sel_ff <= nxt_addr_sel;
      data_ff <= nxt_data;
      unlock_ff <= nxt_unlock;
      out_ff <= nxt_out;
      oe_n_ff <= nxt_oe_n;
      borrow_ff <= nxt_borrow;
      buf_mem_ff <= nxt_buf_mem;
      buf_cnt_ff <= nxt_buf_cnt;
      buf_wp_ff <= nxt_buf_wp;
      buf_rp_ff <= nxt_buf_rp;
      rd_ready_ff <= nxt_rd_ready;
      flash_rd_ff <= nxt_flash_rd;
      flash_rd_vld_ff <= nxt_flash_rd_vld;
      cmd_code <= nxt_buf_mem[nxt_buf_rp];
      cmd_valid <= (nxt_buf_cnt != 2'd0);
    end
  end

  assign debug_data_pin_out = out_ff;
  assign debug_data_pin_oe_n = oe_n_ff;
  assign pins_borrowed = borrow_ff;
  assign prog_enabled = unlock_ff[1];
  assign flash_prog_data = data_ff;
  assign rd_ready = rd_ready_ff;
  logic unused_cmd;
  assign unused_cmd = cmd_is_valid(data_ff);
endmodule : dfp_link

// [sim/dfp_link_monitor.sv]
module dfp_link_monitor #(
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic halted,
  input wire logic debug_data_pin_oe_n,
  input wire logic pins_borrowed,
  input wire logic prog_enabled,
  input wire logic [7:0] flash_prog_data,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [DW-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  borrow_pins_a:
    assert property (halted |=> pins_borrowed) else $error("pins not borrowed");
  abort_idle_a:
    assert property (!halted [*2] |=> debug_data_pin_oe_n) else $error("drive while running");
  drive_gate_a:
    assert property (!debug_data_pin_oe_n |-> pins_borrowed) else $error("drive unborrowed");
  enable_sticky_a:
    assert property (prog_enabled |=> prog_enabled) else $error("enable lost");
  cmd_hold_a:
    assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code))
      else $error("byte dropped");
  cmd_gate_a:
    assert property ($rose(cmd_valid) |-> prog_enabled) else $error("byte while locked");
  unlock_link_a:
    assert property ($rose(prog_enabled) |-> $past(pins_borrowed)) else $error("bad unlock");
  read_load_a:
    assert property (rd_valid && rd_ready |-> ##2 flash_prog_data == $past(rd_data, 2))
      else $error("read byte not loaded");
  cover property (cmd_valid && !cmd_ready);
  cover property (rd_valid && rd_ready);
  cover property (!debug_data_pin_oe_n);
endmodule : dfp_link_monitor

// [sim/dfp_host.sv]
module dfp_host (
  output logic ck,
  output logic hd,
  output logic hen,
  input wire logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ck = 1'b0;
    hd = 1'b0;
    hen = 1'b0;
  end
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] q);
    logic [9:0] bits;
    bits = {wd, ins};
    q = 8'h00;
    for (int i = 0; i < 10; i++) begin
      hen = i < 2 || (ins[0] ^ ins[1]);
      hd = bits[i];
      #100 ck = 1'b1;
      if (i > 1) q[i-2] = pin;
      #100 ck = 1'b0;
    end
    hen = 1'b0;
    #400;
  endtask : frame
endmodule : dfp_host

// [sim/test_dfp_link.sv]
module test_dfp_link;
  timeunit 1ns;
  timeprecision 100ps;
  import dfp_pkg::*;
  logic mclk = 0, sys_rst = 1, halted = 0, cmd_ready = 0, rd_valid = 0;
  logic [7:0] rd_data = 8'h00, q, fpd, code;
  logic ck, hd, hen, pout, oe_n, borrowed, en, cv, rr;
  int bad_count = 0, num_checks = 0, cyc = 0;
  wire logic pin_in = !oe_n ? pout : (hen ? hd : !pout);
  dfp_host host (.ck(ck), .hd(hd), .hen(hen), .pin(pin_in));
  dfp_link DUT (.mclk(mclk), .sys_rst(sys_rst), .halted(halted), .debug_clock_pin(ck),
    .debug_data_pin_in(pin_in), .debug_data_pin_out(pout), .debug_data_pin_oe_n(oe_n),
    .pins_borrowed(borrowed), .prog_enabled(en), .flash_prog_data(fpd), .cmd_code(code),
    .cmd_valid(cv), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rr));
  initial begin
    forever #12.5 mclk = !mclk;
  end
  task automatic check(string what, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic t_unlock;
    halted = 1'b1;
    repeat (3) @(negedge mclk);
    check("borrowed", borrowed, 8'h01);
    host.frame(INS_ADDR_WRITE, ADDR_FLASH_PROG_CONTROL, q);
    host.frame(INS_DATA_WRITE, UNLOCK_SECOND, q);
    check("early enable", en, 8'h00);
    host.frame(INS_DATA_WRITE, UNLOCK_FIRST, q);
    host.frame(INS_DATA_WRITE, UNLOCK_SECOND, q);
    check("enable", en, 8'h01);
  endtask : t_unlock
  task automatic pop(logic [7:0] exp);
    @(negedge mclk);
    check("cmd valid", cv, 8'h01);
    check("cmd code", code, exp);
    cmd_ready = 1'b1;
    @(negedge mclk);
    cmd_ready = 1'b0;
  endtask : pop
  task automatic t_cmds;
    logic [7:0] c [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
    host.frame(INS_ADDR_WRITE, ADDR_FLASH_PROG_DATA, q);
    foreach (c[i]) begin
      host.frame(INS_DATA_WRITE, c[i], q);
      check("data reg", fpd, c[i]);
    end
    pop(CMD_BLOCK_READ);
    pop(CMD_BLOCK_WRITE);
    check("buffer empty", cv, 8'h00);
  endtask : t_cmds
  task automatic t_read;
    rd_data = 8'h5A;
    rd_valid = 1'b1;
    for (int i = 0; i < 20 && rr !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    rd_valid = 1'b0;
    @(negedge mclk);
    check("read load", fpd, 8'h5A);
    host.frame(INS_DATA_READ, 8'h00, q);
    check("link read", q, 8'h5A);
  endtask : t_read
  task automatic t_release;
    halted = 1'b0;
    repeat (3) @(negedge mclk);
    check("released", borrowed, 8'h00);
    check("oe off", oe_n, 8'h01);
    check("still enabled", en, 8'h01);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    check("reset enable", en, 8'h00);
    check("reset data", fpd, RST_FLASH_PROG_DATA);
  endtask : t_release
  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    check("reset data", fpd, RST_FLASH_PROG_DATA);
    check("oe reset", oe_n, 8'h01);
    t_unlock();
    t_cmds();
    t_read();
    t_release();
    summarize();
  end
endmodule : test_dfp_link
bind dfp_link dfp_link_monitor #(.DW(DW)) mon (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .halted(halted),
  .debug_data_pin_oe_n(debug_data_pin_oe_n),
  .pins_borrowed(pins_borrowed),
  .prog_enabled(prog_enabled),
  .flash_prog_data(flash_prog_data),
  .cmd_code(cmd_code),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .rd_ready(rd_ready)
);
